// ---- aer_core.sv ----
// How it works
// - wake selector resets 00; 11 enables sleep-to-wake
// - any event while enabled switches to normal
// - wake never alters the power/rate register
// - filter clear read loads filter state with the raw sample
// - clear read forces filtered axes to zero, except in reference mode 01
// - eight-bit baseline register, reset zero
// - new-data flags per axis and all-axis
// - overrun flags when unread sample overwritten
// - two's-complement axis words in byte pairs
// - six high/low enables against threshold
// - combine and six-direction select event mode
// - read-only flags register, bit 7 zero
// - flags read clears active and pin
// - seven-bit threshold, bit 7 reads zero
// - latch enable holds flags until read
// - duration is outside this block
// - modes 00 and 10 are normal filter
//
// The Avalon-MM slave port was chosen for this implementation.
`include "aer_regs.svh"
module aer_core
	import aer_pkg::*;
#(
	parameter int DW = 16
)(
	// clock and reset
	input  wire logic          clk,
	input  wire logic          nrst,
	// avalon-mm slave, byte addressed; register index taken from address[7:2]
	input  wire logic [7:0]    address,
	input  wire logic          read,
	input  wire logic          write,
	input  wire logic [31:0]   writedata,
	input  wire logic [3:0]    byteenable,
	output logic      [31:0]   readdata,
	output logic               waitrequest,
	// sample source, one pulse per axis sample
	input  wire logic [2:0]    sample_valid,
	input  wire logic [DW-1:0] sample_x,
	input  wire logic [DW-1:0] sample_y,
	input  wire logic [DW-1:0] sample_z,
	// power and event outputs
	output logic               normal_mode,
	output logic               event1_irq,
	output logic               hpf_clear_pulse
);
	// byte lanes and sign handling assume 16-bit axis words
	if (DW != 16)
	begin
		$error("aer_core: only 16-bit axis words supported");
	end

	logic [1:0]   wake_mode_sel_ff;
	logic         woke_ff;
	logic [7:0]   hpf_baseline_value_ff;
	logic [7:0]   cfg_ff;
	logic [6:0]   event1_threshold_value_ff;
	logic [3:0]   fctl_ff;
	logic [3:0]   new_ff;
	logic [3:0]   ovr_ff;
	logic [6:0]   src_ff;
	logic [15:0]  ax_ff [3];
	logic [15:0]  hp_ff [3];
	aer_bus_t     bus_ff;
	logic [31:0]  readdata_ff;
	logic         hpf_clear_pulse_ff;

	// fctl: [0] filtered_out_sel [1] event1_hpf_enable [3:2] hpf_mode_sel
	logic filt_on;
	logic acc_rd;
	logic acc_wr;
	logic be0;
	logic [5:0] idx;
	assign filt_on = fctl_ff[0] | fctl_ff[1];
	assign idx = address[7:2];
	assign be0 = byteenable[0];

	// one wait cycle then accept
	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
			bus_ff <= AER_IDLE;
		else
		begin
			unique case (bus_ff)
				AER_IDLE: if (read | write) bus_ff <= AER_WAIT;
				AER_WAIT: bus_ff <= AER_DONE;
				AER_DONE: bus_ff <= AER_IDLE;
				default:  bus_ff <= AER_IDLE;
			endcase
		end
	end
	assign waitrequest = !(bus_ff == AER_WAIT);
	assign acc_rd = read & (bus_ff == AER_WAIT);
	assign acc_wr = write & (bus_ff == AER_WAIT) & be0;

	function automatic logic [15:0] filt(input logic [15:0] raw, input logic [15:0] hp,
		input logic [7:0] base, input logic [1:0] mode);
		if (mode == `AER_HPM_REF)
			filt = raw - {{8{base[7]}}, base};
		else
			filt = raw - hp;
	endfunction

	logic [15:0] out_w [3];
	always_comb
	begin
		for (int i = 0; i < 3; i++)
			out_w[i] = fctl_ff[0] ? filt(ax_ff[i], hp_ff[i], hpf_baseline_value_ff, fctl_ff[3:2]) : ax_ff[i];
	end

	// read mux; unmapped reads zero
	always_comb
	begin
		readdata = readdata_ff;
	end
	logic [7:0] rmux;
	always_comb
	begin
		rmux = 8'h00;
		unique case (idx)
			`AER_IDX_WAKE:  rmux = {6'h00, wake_mode_sel_ff};
			`AER_IDX_BASE:  rmux = hpf_baseline_value_ff;
			`AER_IDX_FLAGS: rmux = {ovr_ff, new_ff};
			`AER_IDX_XL:    rmux = out_w[0][7:0];
			`AER_IDX_XH:    rmux = out_w[0][15:8];
			`AER_IDX_YL:    rmux = out_w[1][7:0];
			`AER_IDX_YH:    rmux = out_w[1][15:8];
			`AER_IDX_ZL:    rmux = out_w[2][7:0];
			`AER_IDX_ZH:    rmux = out_w[2][15:8];
			`AER_IDX_CFG:   rmux = cfg_ff;
			`AER_IDX_SRC:   rmux = {1'b0, src_ff};
			`AER_IDX_THS:   rmux = {1'b0, event1_threshold_value_ff};
			`AER_IDX_FCTL:  rmux = {4'h0, fctl_ff};
			default:        rmux = 8'h00;
		endcase
	end
	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
			readdata_ff <= 32'h00000000;
		else if (read & (bus_ff == AER_IDLE))
			readdata_ff <= {24'h000000, rmux};
	end

	// writable registers; read-only offsets take no write
	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
		begin
			wake_mode_sel_ff          <= `AER_RST_WAKE;
			hpf_baseline_value_ff     <= `AER_RST_BYTE;
			cfg_ff                    <= `AER_RST_BYTE;
			event1_threshold_value_ff <= `AER_RST_THS;
			fctl_ff                   <= 4'h0;
		end
		else if (acc_wr)
		begin
			unique case (idx)
				`AER_IDX_WAKE: wake_mode_sel_ff <= writedata[1:0];
				`AER_IDX_BASE: hpf_baseline_value_ff <= writedata[7:0];
				`AER_IDX_CFG:  cfg_ff <= writedata[7:0];
				`AER_IDX_THS:  event1_threshold_value_ff <= writedata[6:0];
				`AER_IDX_FCTL: fctl_ff <= writedata[3:0];
				default: ;
			endcase
		end
	end

	// filter clear read
	logic hp_clr;
	assign hp_clr = acc_rd & (idx == `AER_IDX_HPCLR);
	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
			hpf_clear_pulse_ff <= 1'b0;
		else
			hpf_clear_pulse_ff <= hp_clr;
	end
	assign hpf_clear_pulse = hpf_clear_pulse_ff;

	// sample capture; filter state follows raw so clear yields 0g
	logic [2:0] rd_hi;
	assign rd_hi[0] = acc_rd & (idx == `AER_IDX_XH);
	assign rd_hi[1] = acc_rd & (idx == `AER_IDX_YH);
	assign rd_hi[2] = acc_rd & (idx == `AER_IDX_ZH);
	logic [15:0] smp [3];
	assign smp[0] = sample_x;
	assign smp[1] = sample_y;
	assign smp[2] = sample_z;
	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
		begin
			for (int i = 0; i < 3; i++)
			begin
				ax_ff[i] <= 16'h0000;
				hp_ff[i] <= 16'h0000;
			end
		end
		else
		begin
			for (int i = 0; i < 3; i++)
			begin
				if (sample_valid[i])
					ax_ff[i] <= smp[i];
				if (hp_clr)
					hp_ff[i] <= sample_valid[i] ? smp[i] : ax_ff[i];
				else if (sample_valid[i])
					hp_ff[i] <= hp_ff[i] + 16'((signed'(smp[i]) - signed'(hp_ff[i])) >>> 6);
			end
		end
	end

	// data flags: set wins over read-clear
	logic all_set;
	assign all_set = (&(new_ff[2:0] | sample_valid)) & (|sample_valid);
	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
		begin
			new_ff <= 4'h0;
			ovr_ff <= 4'h0;
		end
		else
		begin
			for (int i = 0; i < 3; i++)
			begin
				if (sample_valid[i])
					new_ff[i] <= 1'b1;
				else if (rd_hi[i])
					new_ff[i] <= 1'b0;
				if (sample_valid[i] & new_ff[i])
					ovr_ff[i] <= 1'b1;
				else if (rd_hi[i])
					ovr_ff[i] <= 1'b0;
			end
			if (all_set)
				new_ff[3] <= 1'b1;
			else if (|rd_hi)
				new_ff[3] <= 1'b0;
			if (all_set & new_ff[3])
				ovr_ff[3] <= 1'b1;
			else if (|rd_hi)
				ovr_ff[3] <= 1'b0;
		end
	end

	// event engine on signed axis vs threshold (magnitude compare)
	logic [15:0] ev_w [3];
	logic [5:0]  hit;
	logic [5:0]  en;
	logic        ev_any;
	logic [15:0] th;
	aer_mode_t   mode;
	assign mode = aer_mode_t'(cfg_ff[7:6]);
	assign en = cfg_ff[5:0];
	assign th = {1'b0, event1_threshold_value_ff, 8'h00};
	always_comb
	begin
		for (int i = 0; i < 3; i++)
		begin
			ev_w[i] = fctl_ff[1] ? filt(ax_ff[i], hp_ff[i], hpf_baseline_value_ff, fctl_ff[3:2]) : ax_ff[i];
			hit[2*i+1] = signed'(ev_w[i]) > signed'(th);
			hit[2*i]   = signed'(ev_w[i]) < -signed'(th);
		end
		unique case (mode)
			AER_OR, AER_MOVE: ev_any = |(hit & en);
			AER_AND, AER_POS: ev_any = (en != 6'h00) & ((hit & en) == en);
		endcase
	end
	// persistence counted in samples, so the step follows the output rate
	logic [6:0] dur_ff;
	logic       ev_ok;
	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
			dur_ff <= 7'h00;
		else if (!ev_any)
			dur_ff <= 7'h00;
		else if ((|sample_valid) && (dur_ff != 7'h7F))
			dur_ff <= dur_ff + 7'h01;
	end
	assign ev_ok = ev_any & (dur_ff >= `AER_RST_DUR);
	logic src_rd;
	logic [5:0] prev_ff;
	assign src_rd = acc_rd & (idx == `AER_IDX_SRC);
	// latch enable rides on filter mode code 11, which selects no filter mode of its own
	logic latch;
	assign latch = fctl_ff[3] & fctl_ff[2];
	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
		begin
			src_ff  <= 7'h00;
			prev_ff <= 6'h00;
		end
		else
		begin
			prev_ff <= hit & en;
			if (ev_ok & (mode != AER_MOVE || (hit & en) != prev_ff))
				src_ff <= {1'b1, hit & en};
			else if (src_rd | !latch)
				src_ff <= {1'b0, latch ? 6'h00 : (hit & en)};
		end
	end
	assign event1_irq = src_ff[6];

	// wake: any event raises rate; power/rate register is elsewhere and untouched
	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
			woke_ff <= 1'b0;
		else if (wake_mode_sel_ff != `AER_WAKE_ON)
			woke_ff <= 1'b0;
		else if (ev_ok)
			woke_ff <= 1'b1;
	end
	assign normal_mode = (wake_mode_sel_ff != `AER_WAKE_ON) | woke_ff;

	wake_normal_a: assert property (@(posedge clk) disable iff (!nrst) (wake_mode_sel_ff == `AER_WAKE_ON && ev_ok) |=> normal_mode)
		else $error("event did not wake");
	clr_pulse_a: assert property (@(posedge clk) disable iff (!nrst) hp_clr |=> hpf_clear_pulse)
		else $error("clear read not seen");
	irq_clear_a: assert property (@(posedge clk) disable iff (!nrst) (src_rd & latch & !ev_any) |=> !event1_irq)
		else $error("flags read did not clear");
	ovr_set_a: assert property (@(posedge clk) disable iff (!nrst) (sample_valid[0] & new_ff[0]) |=> ovr_ff[0])
		else $error("overrun missed");
	new_set_a: assert property (@(posedge clk) disable iff (!nrst) sample_valid[1] |=> new_ff[1])
		else $error("new data missed");
	ths_zero_a: assert property (@(posedge clk) disable iff (!nrst) (read & (bus_ff == AER_IDLE) & (idx == `AER_IDX_THS)) |=> (readdata[7:0] == {1'b0, event1_threshold_value_ff}))
		else $error("threshold readback wrong");
	bus_wait_a: assert property (@(posedge clk) disable iff (!nrst) ((bus_ff == AER_IDLE) & (read | write)) |=> !waitrequest)
		else $error("request not answered");
	hpf_zero_a: assert property (@(posedge clk) disable iff (!nrst) (hp_clr & fctl_ff[0] & (fctl_ff[3:2] != `AER_HPM_REF)) |=> (out_w[0] == 16'h0000 && out_w[1] == 16'h0000 && out_w[2] == 16'h0000))
		else $error("filter clear left output nonzero");
endmodule

// ---- aer_regs.svh ----
`ifndef AER_REGS_SVH
`define AER_REGS_SVH
// register indices, not byte offsets: index*4 is the byte address
`define AER_IDX_WAKE     6'h24
`define AER_IDX_HPCLR    6'h25
`define AER_IDX_BASE     6'h26
`define AER_IDX_FLAGS    6'h27
`define AER_IDX_XL       6'h28
`define AER_IDX_XH       6'h29
`define AER_IDX_YL       6'h2A
`define AER_IDX_YH       6'h2B
`define AER_IDX_ZL       6'h2C
`define AER_IDX_ZH       6'h2D
`define AER_IDX_CFG      6'h30
`define AER_IDX_SRC      6'h31
`define AER_IDX_THS      6'h32
// side-band control register, local choice
`define AER_IDX_FCTL     6'h3C
// fields
`define AER_WAKE_ON      2'h3
`define AER_HPM_REF      2'h1
`define AER_RST_BYTE     8'h00
`define AER_RST_THS      7'h00
`define AER_RST_WAKE     2'h0
`define AER_RD_LAT       2'h2
// minimum event persistence in samples; its register is not part of this block
`define AER_RST_DUR      7'h00
`endif

// ---- aer_pkg.sv ----
package aer_pkg;
	typedef enum logic [1:0] {AER_IDLE, AER_WAIT, AER_DONE} aer_bus_t;
	typedef enum logic [1:0] {AER_OR, AER_MOVE, AER_AND, AER_POS} aer_mode_t;
endpackage

// ---- aer_src.sv ----
module aer_src
(
	// clock
	input  wire logic        clk,
	// sample stream
	output logic      [2:0]  sample_valid,
	output logic      [15:0] sample_x,
	output logic      [15:0] sample_y,
	output logic      [15:0] sample_z
);
	timeunit 1ns;
	timeprecision 1ns;
	initial
	begin
		sample_valid = 3'h0;
		sample_x = 16'h0000;
		sample_y = 16'h0000;
		sample_z = 16'h0000;
	end
	// one whole x,y,z set; lines scrambled outside the pulse so stale values never match
	task automatic push(input logic [15:0] x, input logic [15:0] y, input logic [15:0] z);
		@(posedge clk);
		sample_valid <= 3'h7;
		sample_x <= x;
		sample_y <= y;
		sample_z <= z;
		@(posedge clk);
		sample_valid <= 3'h0;
		sample_x <= ~x;
		sample_y <= ~y;
		sample_z <= ~z;
	endtask
endmodule

// ---- tb.sv ----
`define CHK(nm, e, g) begin check_count++; if ((e) !== (g)) begin fail_count++; \
	$display("mismatch %s expected %h seen %h", nm, e, g); end end
module tb;
	timeunit 1ns;
	timeprecision 1ns;
	logic        clk;
	logic        nrst;
	logic [7:0]  address;
	logic        read;
	logic        write;
	logic [31:0] writedata;
	logic [31:0] readdata;
	logic        waitrequest;
	logic [2:0]  sample_valid;
	logic [15:0] sample_x;
	logic [15:0] sample_y;
	logic [15:0] sample_z;
	logic        normal_mode;
	logic        event1_irq;
	logic        hpf_clear_pulse;
	logic [7:0]  d;
	int          fail_count = 0;
	int          check_count = 0;
	int          pulses = 0;
	aer_core dut (.clk(clk), .nrst(nrst), .address(address), .read(read), .write(write),
		.writedata(writedata), .byteenable(4'hF), .readdata(readdata), .waitrequest(waitrequest),
		.sample_valid(sample_valid), .sample_x(sample_x), .sample_y(sample_y), .sample_z(sample_z),
		.normal_mode(normal_mode), .event1_irq(event1_irq), .hpf_clear_pulse(hpf_clear_pulse));
	aer_src src (.clk(clk), .sample_valid(sample_valid), .sample_x(sample_x), .sample_y(sample_y),
		.sample_z(sample_z));
	initial
	begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	always @(posedge clk)
		if (hpf_clear_pulse === 1'b1)
			pulses++;
	task automatic results;
		if (fail_count == 0 && check_count > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	// request held until waitrequest is sampled low at a rising edge; read data taken at that edge
	task automatic bus(input logic w, input logic [5:0] i, input logic [7:0] wd, output logic [7:0] q);
		int n;
		n = 0;
		@(posedge clk);
		address <= {i, 2'h0};
		writedata <= {24'h000000, wd};
		read <= !w;
		write <= w;
		do
		begin
			@(posedge clk);
			n++;
		end
		while (waitrequest !== 1'b0 && n < 40);
		if (waitrequest !== 1'b0)
		begin
			fail_count++;
			results();
		end
		q = readdata[7:0];
		read <= 1'b0;
		write <= 1'b0;
	endtask
	task automatic rchk(input logic [5:0] i, input logic [7:0] e);
		bus(1'b0, i, 8'h00, d);
		`CHK("readdata", e, d)
	endtask
	task automatic reset_chk;
		`CHK("normal_mode", 1'b1, normal_mode)
		`CHK("event1_irq", 1'b0, event1_irq)
		rchk(6'h24, 8'h00);
		rchk(6'h26, 8'h00);
		rchk(6'h27, 8'h00);
		rchk(6'h30, 8'h00);
		rchk(6'h31, 8'h00);
		rchk(6'h32, 8'h00);
	endtask
	task automatic rw_chk;
		bus(1'b1, 6'h26, 8'hA5, d);
		rchk(6'h26, 8'hA5);
		bus(1'b1, 6'h32, 8'hFF, d);
		rchk(6'h32, 8'h7F);
		bus(1'b1, 6'h27, 8'hFF, d);
		rchk(6'h27, 8'h00);
		bus(1'b1, 6'h31, 8'hFF, d);
		rchk(6'h31, 8'h00);
		bus(1'b1, 6'h3F, 8'hFF, d);
		rchk(6'h3F, 8'h00);
	endtask
	task automatic sample_chk;
		src.push(16'h1234, 16'h8001, 16'h7FFE);
		rchk(6'h27, 8'h0F);
		rchk(6'h28, 8'h34);
		rchk(6'h29, 8'h12);
		rchk(6'h2A, 8'h01);
		rchk(6'h2B, 8'h80);
		rchk(6'h2C, 8'hFE);
		rchk(6'h2D, 8'h7F);
		rchk(6'h27, 8'h00);
		src.push(16'h0001, 16'h0002, 16'h0003);
		src.push(16'h0004, 16'h0005, 16'h0006);
		rchk(6'h27, 8'hFF);
		rchk(6'h29, 8'h00);
		rchk(6'h2B, 8'h00);
		rchk(6'h2D, 8'h00);
	endtask
	task automatic event_chk;
		bus(1'b1, 6'h32, 8'h10, d);
		bus(1'b1, 6'h3C, 8'h0C, d);
		bus(1'b1, 6'h30, 8'h02, d);
		bus(1'b1, 6'h24, 8'h03, d);
		rchk(6'h30, 8'h02);
		`CHK("normal_mode", 1'b0, normal_mode)
		`CHK("event1_irq", 1'b0, event1_irq)
		src.push(16'h2000, 16'h0000, 16'h0000);
		src.push(16'h0000, 16'h0000, 16'h0000);
		rchk(6'h24, 8'h03);
		`CHK("event1_irq", 1'b1, event1_irq)
		`CHK("normal_mode", 1'b1, normal_mode)
		rchk(6'h31, 8'h42);
		rchk(6'h31, 8'h00);
		`CHK("event1_irq", 1'b0, event1_irq)
	endtask
	task automatic clear_chk;
		rchk(6'h25, 8'h00);
		rchk(6'h27, 8'hFF);
		`CHK("hpf_clear_pulse", 1, pulses)
		src.push(16'h0100, 16'h0200, 16'h0300);
		bus(1'b1, 6'h3C, 8'h01, d);
		rchk(6'h25, 8'h00);
		rchk(6'h28, 8'h00);
		rchk(6'h2D, 8'h00);
		bus(1'b1, 6'h3C, 8'h05, d);
		rchk(6'h28, 8'h5B);
		rchk(6'h29, 8'h01);
	endtask
	task automatic mode_chk;
		bus(1'b1, 6'h3C, 8'h00, d);
		bus(1'b1, 6'h30, 8'h8A, d);
		src.push(16'h2000, 16'h0000, 16'h0000);
		rchk(6'h30, 8'h8A);
		`CHK("event1_irq", 1'b0, event1_irq)
		src.push(16'h2000, 16'h2000, 16'h0000);
		rchk(6'h31, 8'h4A);
		src.push(16'h0000, 16'h0000, 16'h0000);
		rchk(6'h31, 8'h00);
		`CHK("event1_irq", 1'b0, event1_irq)
	endtask
	initial
	begin
		nrst = 1'b0;
		address = 8'h00;
		read = 1'b0;
		write = 1'b0;
		writedata = 32'h00000000;
		repeat (3) @(posedge clk);
		nrst <= 1'b1;
		@(negedge clk);
		reset_chk();
		rw_chk();
		sample_chk();
		event_chk();
		clear_chk();
		mode_chk();
		results();
	end
endmodule
